// ### rtl/cfs_supervisor.v
`timescale 1ns/1ns
`default_nettype none
`include "cfs_defs.vh"
module cfs_supervisor (
  input  wire                   clk_i,
  input  wire                   rst_n_i,
  input  wire                   sw_tick_i,
  input  wire                   threshold_enable_in_i,
  input  wire                   vcc_por_ok_i,
  input  wire                   driver_supply_por_ok_i,
  input  wire                   ov_fixed_trip_i,
  input  wire                   ov_fixed_clear_i,
  input  wire                   ov_ref_trip_i,
  input  wire                   ov_ref_clear_i,
  input  wire                   uv_i,
  input  wire                   open_sense_i,
  input  wire                   overcurrent_i,
  input  wire                   temp_over_set_i,
  input  wire                   temp_below_rec_i,
  input  wire                   pwm_high_i,
  input  wire                   pwm_low_i,
  output reg  [`CFS_PHASES-1:0] high_side_gate_o,
  output reg  [`CFS_PHASES-1:0] low_side_gate_o,
  output reg                    power_good_out_o,
  output reg                    overvoltage_flag_out_o,
  output reg                    pre_por_clamp_en_o,
  output reg                    soft_start_active_o,
  output reg                    ov_ref_select_o
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and comparator synchronisation.

  reg rst_meta;
  reg rst_n;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  wire [10:0] raw_in = {ov_fixed_trip_i, ov_fixed_clear_i, ov_ref_trip_i, ov_ref_clear_i, uv_i,
                        open_sense_i, overcurrent_i, temp_over_set_i, temp_below_rec_i,
                        vcc_por_ok_i, driver_supply_por_ok_i};
  wire [10:0] s;
  cfs_sync #(.W(11)) u_sync (
    .clk_i (clk_i),
    .rst_n (rst_n),
    .d_i   (raw_in),
    .q_o   (s)
  );
  wire ovf_trip = s[10];
  wire ovf_clr  = s[9];
  wire ovr_trip = s[8];
  wire ovr_clr  = s[7];
  wire uv       = s[6];
  wire open_s   = s[5];
  wire oc       = s[4];
  wire t_hot    = s[3];
  wire t_cool   = s[2];
  wire por_ok   = s[1] & s[0];

////////////////////////////////////////////////////////////////////////////////
// Fault sequencer.

  reg [2:0]                 state;
  reg [2:0]                 next_state;
  reg [`CFS_SS_CNT_W-1:0]   ss_cnt;
  reg [`CFS_OC_CNT_W-1:0]   oc_cnt;
  reg                       ss_done;
  reg                       ov_active;
  reg                       hot;
  wire                      enabled = por_ok & threshold_enable_in_i;

  // Hot latches at the set point and only releases at the recovery point.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hot <= 1'b0;
    end else if (t_hot) begin
      hot <= 1'b1;
    end else if (t_cool) begin
      hot <= 1'b0;
    end
  end

  // The fixed level applies until soft-start finishes, then the reference level.
  wire ov_trip = ss_done ? ovr_trip : ovf_trip;
  wire ov_clr  = ss_done ? ovr_clr : ovf_clr;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ov_active <= 1'b0;
    end else if (!enabled) begin
      ov_active <= 1'b0;
    end else if (ov_trip) begin
      ov_active <= 1'b1;
    end else if (ov_clr) begin
      ov_active <= 1'b0;
    end
  end

  always @* begin
    next_state = state;
    if (!enabled || hot || open_s) begin
      next_state = `CFS_ST_HALT;
    end else begin
      case (state)
        `CFS_ST_HALT:
          next_state = `CFS_ST_SOFT;
        `CFS_ST_OFF:
          next_state = `CFS_ST_SOFT;
        `CFS_ST_SOFT: begin
          if (oc) begin
            next_state = `CFS_ST_OC_WAIT;
          end else if (sw_tick_i && ss_cnt == `CFS_SS_CYCLES - 16'h0001) begin
            next_state = `CFS_ST_RUN;
          end
        end
        `CFS_ST_RUN:
          if (oc) begin
            next_state = `CFS_ST_OC_WAIT;
          end
        `CFS_ST_OC_WAIT:
          if (sw_tick_i && oc_cnt == `CFS_OC_LAST) begin
            next_state = `CFS_ST_SOFT;
          end
        default:
          next_state = `CFS_ST_HALT;
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state   <= `CFS_ST_OFF;
      ss_cnt  <= {`CFS_SS_CNT_W{1'b0}};
      oc_cnt  <= {`CFS_OC_CNT_W{1'b0}};
      ss_done <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        ss_cnt <= {`CFS_SS_CNT_W{1'b0}};
        oc_cnt <= {`CFS_OC_CNT_W{1'b0}};
      end else if (sw_tick_i) begin
        if (state == `CFS_ST_SOFT) begin
          ss_cnt <= ss_cnt + 16'h0001;
        end
        if (state == `CFS_ST_OC_WAIT) begin
          oc_cnt <= oc_cnt + 13'h0001;
        end
      end
      ss_done <= (next_state == `CFS_ST_RUN);
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Outputs, registered so the pins never glitch during decoding.

  // Only soft-start and regulation pass the control loop's requests to the switches.
  wire switching = (state == `CFS_ST_RUN) || (state == `CFS_ST_SOFT);

  // Overvoltage takes priority over switching and shutdown states; otherwise shutdown states drive nothing.
  // Each phase has its own flops so a later per-phase mask needs no rework here.
  genvar ph;
  generate
    for (ph = 0; ph < `CFS_PHASES; ph = ph + 1) begin : g_phase
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          high_side_gate_o[ph] <= 1'b0;
          low_side_gate_o[ph]  <= 1'b0;
        end else if (ov_active && enabled) begin
          high_side_gate_o[ph] <= 1'b0;
          low_side_gate_o[ph]  <= 1'b1;
        end else if (switching) begin
          high_side_gate_o[ph] <= pwm_high_i;
          low_side_gate_o[ph]  <= pwm_low_i;
        end else begin
          high_side_gate_o[ph] <= 1'b0;
          low_side_gate_o[ph]  <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_good_out_o       <= 1'b0;
      overvoltage_flag_out_o <= 1'b0;
      pre_por_clamp_en_o     <= 1'b1;
      soft_start_active_o    <= 1'b0;
      ov_ref_select_o        <= 1'b0;
    end else begin
      pre_por_clamp_en_o     <= ~por_ok;
      overvoltage_flag_out_o <= ov_active & enabled;
      soft_start_active_o    <= (next_state == `CFS_ST_SOFT);
      ov_ref_select_o        <= (next_state == `CFS_ST_RUN);
      power_good_out_o <= (next_state == `CFS_ST_RUN) && !ov_active && !uv && !oc
                          && enabled;
    end
  end
endmodule // cfs_supervisor
`default_nettype wire

// ### rtl/cfs_defs.vh
// Contract
// - Fixed OV trip until soft-start done, then reference-based
// - OV flag clears only below trip hysteresis
// - During OV: flag high, power good low
// - OV start commands all low gates on
// - Hold low gates until back in limits; repeat
// - OV end resumes regulation, power good returns
// - Supply below POR re-enables pre-POR clamp
// - Local sense above diff plus 1V shuts down
// - Open sense cleared restarts from soft-start
// - Droop above threshold starts overcurrent procedure
// - Overcurrent shutdown turns off all gates; code still turns low gates on during OV
// - Overcurrent off lasts 4096 switching cycles
// - After wait, retry soft-start if enabled
// - Trip-wait-retry repeats without limit
// - Overtemperature disables logic and all gates; code still turns low gates on during OV
// - Cool-down reruns initialization and soft-start
// - Power good low in shutdown, high after soft-start
// - Power good low on UV, OV, OC, disable
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH
`define CFS_PHASES        3
`define CFS_OC_WAIT       4096
`define CFS_OC_LAST       13'h0fff
`define CFS_OC_CNT_W      13
`define CFS_SS_CNT_W      16
`define CFS_SS_CYCLES     16'h0580
`define CFS_OV_RISE_MV    150
`define CFS_OV_HYST_MV    100
`define CFS_OPEN_OFS_MV   1000
`define CFS_ST_OFF        3'h0
`define CFS_ST_SOFT       3'h1
`define CFS_ST_RUN        3'h2
`define CFS_ST_OC_WAIT    3'h3
`define CFS_ST_HALT       3'h4
`endif

// ### rtl/cfs_sync.v
`timescale 1ns/1ns
`default_nettype none
module cfs_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_n,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          meta[g] <= 1'b0;
          q_o[g]  <= 1'b0;
        end else begin
          meta[g] <= d_i[g];
          q_o[g]  <= meta[g];
        end
      end
    end
  endgenerate
endmodule // cfs_sync
`default_nettype wire

// ### test/cfs_supervisor_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor_asserts (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       vcc_por_ok_i,
  input wire logic       driver_supply_por_ok_i,
  input wire logic       ov_ref_trip_i,
  input wire logic       open_sense_i,
  input wire logic       overcurrent_i,
  input wire logic       temp_over_set_i,
  input wire logic [2:0] high_side_gate_o,
  input wire logic [2:0] low_side_gate_o,
  input wire logic       power_good_out_o,
  input wire logic       overvoltage_flag_out_o,
  input wire logic       pre_por_clamp_en_o,
  input wire logic       soft_start_active_o,
  input wire logic       ov_ref_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ov_pg_low: assert property (overvoltage_flag_out_o |-> !power_good_out_o)
    else $error("power_good_out high in overvoltage");
  a_ov_low_on: assert property (overvoltage_flag_out_o |-> low_side_gate_o == 3'h7)
    else $error("low gates off in overvoltage");
  a_ref_trip: assert property ($rose(ov_ref_trip_i) && ov_ref_select_o
    |-> ##[1:6] overvoltage_flag_out_o) else $error("reference trip missed");
  a_oc_gates_off: assert property ((overcurrent_i && power_good_out_o)[*3]
    |-> ##[1:6] (high_side_gate_o == 3'h0 && low_side_gate_o == 3'h0))
    else $error("gates on after overcurrent");
  a_oc_pg_low: assert property ($rose(overcurrent_i) |-> ##[1:6] !power_good_out_o)
    else $error("power_good_out high after overcurrent");
  a_hot_halt: assert property (temp_over_set_i[*3] |-> ##[1:6] (!power_good_out_o
    && high_side_gate_o == 3'h0 && low_side_gate_o == 3'h0)) else $error("hot but running");
  a_open_halt: assert property (open_sense_i[*3] |-> ##[1:6] (!power_good_out_o
    && high_side_gate_o == 3'h0)) else $error("open sense but running");
  a_por_clamp: assert property ((!vcc_por_ok_i || !driver_supply_por_ok_i)[*3]
    |-> ##[1:4] pre_por_clamp_en_o) else $error("clamp off below supply threshold");
  a_soft_pg: assert property (soft_start_active_o |-> !power_good_out_o)
    else $error("power_good_out high in soft start");
  cover property (overvoltage_flag_out_o);
  cover property ($fell(soft_start_active_o));
  cover property ($rose(pre_por_clamp_en_o));
endmodule // cfs_supervisor_asserts
bind cfs_supervisor cfs_supervisor_asserts u_chk (.*);
`default_nettype wire

// ### test/cfs_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_stage_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] high_side_gate_o,
  input  wire logic [2:0] low_side_gate_o,
  output var  logic       short_o
);
  initial short_o = 1'b0;
  // Both switches of one phase on shorts the input rail, so it is latched for the bench.
  always @(posedge clk_i) begin
    if ((high_side_gate_o & low_side_gate_o) != 3'h0) begin
      short_o <= 1'b1;
    end
  end
endmodule // cfs_stage_model
`default_nettype wire

// ### test/cfs_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor_tb;
  logic clk_i = 0, rst_n_i = 0, sw_tick_i = 1, threshold_enable_in_i = 0, uv_i = 0;
  logic vcc_por_ok_i = 0, driver_supply_por_ok_i = 0, ov_fixed_trip_i = 0;
  logic ov_fixed_clear_i = 1, ov_ref_trip_i = 0, ov_ref_clear_i = 1, open_sense_i = 0;
  logic overcurrent_i = 0, temp_over_set_i = 0, temp_below_rec_i = 1;
  logic pwm_high_i = 0, pwm_low_i = 1, short_o, power_good_out_o, overvoltage_flag_out_o;
  logic pre_por_clamp_en_o, soft_start_active_o, ov_ref_select_o;
  logic [2:0] high_side_gate_o, low_side_gate_o;
  int err_count = 0, check_count = 0, n;
  cfs_supervisor dut (.*);
  cfs_stage_model stage (.*);
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    pwm_high_i <= ~pwm_high_i;
    pwm_low_i <= pwm_high_i;
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Sampling on the falling edge keeps reads clear of the design's own updates.
  task automatic cyc(int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic wait_pg();
    for (n = 0; power_good_out_o !== 1'b1 && n < 8000; n++) begin
      cyc(1);
    end
    chk("power good", power_good_out_o, 1'b1);
  endtask
  task automatic t_ov();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      ov_ref_trip_i <= 1;
      ov_ref_clear_i <= 0;
      cyc(6);
      chk("ov flag", {overvoltage_flag_out_o, power_good_out_o}, 2'b10);
      chk("low gates", low_side_gate_o, 3'h7);
      @(posedge clk_i);
      ov_ref_trip_i <= 0;
      cyc(6);
      chk("ov held", {overvoltage_flag_out_o, low_side_gate_o}, 4'hf);
      @(posedge clk_i);
      ov_ref_clear_i <= 1;
      cyc(6);
      chk("ov end", {overvoltage_flag_out_o, power_good_out_o, soft_start_active_o}, 3'h2);
    end
  endtask
  task automatic t_oc();
    @(posedge clk_i);
    overcurrent_i <= 1;
    for (int i = 0; i < 2; i++) begin
      for (n = 0; (soft_start_active_o | (|high_side_gate_o) | (|low_side_gate_o)) && n < 3000; n++) begin
        cyc(1);
      end
      chk("oc gates", {soft_start_active_o, high_side_gate_o, low_side_gate_o}, 7'h0);
      for (n = 0; soft_start_active_o !== 1'b1 && n < 5000; n++) begin
        cyc(1);
      end
      chk("oc wait", n >= 4094 && n <= 4098, 1'b1);
    end
    @(posedge clk_i);
    overcurrent_i <= 0;
    wait_pg();
  endtask
  task automatic t_halt();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      open_sense_i <= (k == 0);
      temp_over_set_i <= (k == 1);
      temp_below_rec_i <= (k != 1);
      threshold_enable_in_i <= (k != 2);
      cyc(8);
      chk("halt", {high_side_gate_o, low_side_gate_o, power_good_out_o}, 7'h0);
      @(posedge clk_i);
      open_sense_i <= 0;
      temp_over_set_i <= 0;
      temp_below_rec_i <= 1;
      threshold_enable_in_i <= 1;
      cyc(8);
      chk("restart", soft_start_active_o, 1'b1);
      wait_pg();
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1;
    cyc(6);
    chk("clamp", {pre_por_clamp_en_o, power_good_out_o}, 2'b10);
    @(posedge clk_i);
    vcc_por_ok_i <= 1;
    driver_supply_por_ok_i <= 1;
    threshold_enable_in_i <= 1;
    cyc(8);
    chk("soft", {soft_start_active_o, power_good_out_o, ov_ref_select_o}, 3'h4);
    wait_pg();
    chk("ref trip", ov_ref_select_o, 1'b1);
    t_ov();
    t_oc();
    t_halt();
    @(posedge clk_i);
    uv_i <= 1;
    cyc(6);
    chk("uv pg", {power_good_out_o, soft_start_active_o}, 2'b00);
    @(posedge clk_i);
    uv_i <= 0;
    cyc(6);
    chk("uv end", power_good_out_o, 1'b1);
    @(posedge clk_i);
    uv_i <= 1;
    driver_supply_por_ok_i <= 0;
    cyc(6);
    chk("por", {pre_por_clamp_en_o, power_good_out_o}, 2'b10);
    @(posedge clk_i);
    uv_i <= 0;
    driver_supply_por_ok_i <= 1;
    wait_pg();
    chk("shoot", short_o, 1'b0);
    results();
  end
  initial begin
    #1600000;
    err_count++;
    results();
  end
endmodule // cfs_supervisor_tb
`default_nettype wire
